// File: rtl/fault_int_params.svh
// Register offsets, field positions and reset values of the fault and event interrupt bank
`ifndef FAULT_INT_PARAMS_SVH
`define FAULT_INT_PARAMS_SVH

// ==========================================
// Register offsets on the control port
`define ADDR_MASK_ZERO     8'h2F
`define ADDR_MASK_FOUR     8'h32
`define ADDR_MASK_FIVE     8'h33
`define ADDR_LATCH_ZERO    8'h34
`define ADDR_SUMMARY       8'h35
`define ADDR_CH1_LATCH     8'h38

// ==========================================
// Reset values
`define RST_MASK_ZERO      8'hC0
`define RST_MASK_FOUR      8'h00
`define RST_MASK_FIVE      8'h30
`define RST_LATCH          8'h00
`define RST_BYTE_ZERO      8'h00

// ==========================================
// Writable and implemented bits, the rest read as zero
`define WMASK_MASK_ZERO    8'hC0
`define WMASK_MASK_FOUR    8'h3E
`define WMASK_MASK_FIVE    8'hF0
`define IMPL_LATCH_ZERO    8'hC0
`define IMPL_SUMMARY       8'h30
`define IMPL_CH1_LATCH     8'hF0

// ==========================================
// Field positions
`define BIT_CLOCK_ERROR    7
`define BIT_PLL_LOCK       6
`define BIT_OUT_SHORT      5
`define BIT_DRIVER_VGND    4
`define BIT_HS_INSERT      3
`define BIT_HS_REMOVE      2
`define BIT_HS_BUTTON      1
`define BIT_GPA_UPPER      7
`define BIT_GPA_LOWER      6
`define BIT_VOICE_UP       5
`define BIT_VOICE_DOWN     4
`define BIT_CH1_SUMMARY    5
`define BIT_CH2_SUMMARY    4
`define BIT_CH1_SHORT_POS  7
`define BIT_CH1_SHORT_NEG  6
`define BIT_CH1_VGND_POS   5
`define BIT_CH1_VGND_NEG   4

`endif

// File: rtl/fault_int_pkg.sv
// State types of the fault and event interrupt bank
package fault_int_pkg;

   typedef struct packed {
      logic [7:0] mask_zero;
      logic [7:0] mask_four;
      logic [7:0] mask_five;
      logic [7:0] rdata;
      logic       rvalid;
      logic       irq;
   } ctrl_state_t;

   typedef struct packed {
      logic [7:0] flags;
   } latch_state_t;

endpackage

// File: rtl/latched_event_byte.sv
// One byte of sticky event flags, cleared by a read strobe
`timescale 1ns/1ps
`include "fault_int_params.svh"

module latched_event_byte
   import fault_int_pkg::*;
#(
   parameter logic [7:0] IMPL = 8'hFF
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic [7:0] set_evt,
   input  wire logic       clear,
   output logic      [7:0] flags
);

   latch_state_t q;
   latch_state_t next_q;

   // ==========================================
   // Set wins over a clear in the same cycle
   always_comb begin
      next_q = q;
      if (clk_en) begin
         next_q.flags = (q.flags & ~{8{clear}}) | (set_evt & IMPL);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q.flags <= `RST_LATCH;
      end else begin
         q <= next_q;
      end
   end

   assign flags = q.flags;

endmodule // latched_event_byte

// File: rtl/fault_interrupt_mask_latch.sv
// Interrupt masks and latched fault and event flags with the interrupt output
//
// Function
// - Mask four bit 5 set suppresses the output short-circuit interrupt.
// - Mask four bit 4 set suppresses the driver virtual-ground interrupt.
// - Mask four bits 3..1 mask headset insert, remove and button interrupts.
// - Mask four sits at 0x32 and resets to 0x00.
// - Mask five bits 7 and 6 mask upper and lower input threshold interrupts.
// - Mask five bit 5 masks voice-activity power-up; resets to one.
// - Mask five bit 4 masks voice-activity power-down; resets to one.
// - Mask five sits at 0x33 and resets to 0x30.
// - Latched zero bit 7 catches a clock error and holds it until latched zero is read.
// - Latched zero bit 6 catches a PLL lock event and holds it until latched zero is read.
// - Summary bit 5 reads one once channel 1 has seen a fault.
// - Summary bit 4 reads one once channel 2 has seen a fault.
// - Channel 1 latch bit 7 catches a positive output short.
// - Channel 1 latch bit 6 catches a negative output short.
// - Channel 1 latch bit 5 catches a positive driver virtual-ground fault.
// - Channel 1 latch bit 4 catches a negative driver virtual-ground fault.
// - Mask zero bits 7 and 6 mask clock error and PLL lock; reset one.
`timescale 1ns/1ps
`include "fault_int_params.svh"

module fault_interrupt_mask_latch
   import fault_int_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Register port behind the control interface
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Event pulses from the detectors
   input  wire logic       clock_error_evt,
   input  wire logic       pll_lock_evt,
   input  wire logic       ch1_short_pos_evt,
   input  wire logic       ch1_short_neg_evt,
   input  wire logic       ch1_vgnd_pos_evt,
   input  wire logic       ch1_vgnd_neg_evt,
   input  wire logic       ch2_fault_evt,
   // Levels of flags latched in neighbouring registers
   input  wire logic       ch2_short_flag,
   input  wire logic       ch2_vgnd_flag,
   input  wire logic       hs_insert_flag,
   input  wire logic       hs_remove_flag,
   input  wire logic       hs_button_flag,
   input  wire logic       gpa_upper_flag,
   input  wire logic       gpa_lower_flag,
   input  wire logic       voice_up_flag,
   input  wire logic       voice_down_flag,
   // Interrupt to the host
   output logic            irq
);

   ctrl_state_t q;
   ctrl_state_t next_q;

   logic [7:0] latch_zero;
   logic [7:0] summary;
   logic [7:0] ch1_latch;
   logic [7:0] latch_zero_set;
   logic [7:0] summary_set;
   logic [7:0] ch1_set;
   logic       ch1_any;
   logic       rd_latch_zero;
   logic       rd_summary;
   logic       rd_ch1;
   logic [7:0] mask_four_src;
   logic [7:0] mask_five_src;

   // ==========================================
   // Helpers
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   function automatic logic unmasked(input logic [7:0] flags, input logic [7:0] mask);
      unmasked = |(flags & ~mask);
   endfunction

   // ==========================================
   // Event vectors aligned to their register bits
   assign ch1_any = ch1_short_pos_evt | ch1_short_neg_evt | ch1_vgnd_pos_evt | ch1_vgnd_neg_evt;

   always_comb begin
      latch_zero_set = `RST_BYTE_ZERO;
      latch_zero_set[`BIT_CLOCK_ERROR] = clock_error_evt;
      latch_zero_set[`BIT_PLL_LOCK]    = pll_lock_evt;
      ch1_set = `RST_BYTE_ZERO;
      ch1_set[`BIT_CH1_SHORT_POS] = ch1_short_pos_evt;
      ch1_set[`BIT_CH1_SHORT_NEG] = ch1_short_neg_evt;
      ch1_set[`BIT_CH1_VGND_POS]  = ch1_vgnd_pos_evt;
      ch1_set[`BIT_CH1_VGND_NEG]  = ch1_vgnd_neg_evt;
      summary_set = `RST_BYTE_ZERO;
      summary_set[`BIT_CH1_SUMMARY] = ch1_any;
      summary_set[`BIT_CH2_SUMMARY] = ch2_fault_evt;
   end

   // Reads of latched zero, summary or channel 1 latch clear the register that was read
   assign rd_latch_zero = reg_rd & hit(reg_addr, `ADDR_LATCH_ZERO);
   assign rd_summary    = reg_rd & hit(reg_addr, `ADDR_SUMMARY);
   assign rd_ch1        = reg_rd & hit(reg_addr, `ADDR_CH1_LATCH);

   // ==========================================
   // Sticky flag bytes
   latched_event_byte #(
      .IMPL (`IMPL_LATCH_ZERO)
   ) u_latch_zero (
      .clk     (clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .set_evt (latch_zero_set),
      .clear   (rd_latch_zero),
      .flags   (latch_zero)
   );

   latched_event_byte #(
      .IMPL (`IMPL_SUMMARY)
   ) u_summary (
      .clk     (clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .set_evt (summary_set),
      .clear   (rd_summary),
      .flags   (summary)
   );

   latched_event_byte #(
      .IMPL (`IMPL_CH1_LATCH)
   ) u_ch1_latch (
      .clk     (clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .set_evt (ch1_set),
      .clear   (rd_ch1),
      .flags   (ch1_latch)
   );

   // ==========================================
   // Interrupt sources lined up with mask bits
   always_comb begin
      mask_four_src = `RST_BYTE_ZERO;
      mask_four_src[`BIT_OUT_SHORT]   = ch1_latch[`BIT_CH1_SHORT_POS] | ch1_latch[`BIT_CH1_SHORT_NEG]
                                      | ch2_short_flag;
      mask_four_src[`BIT_DRIVER_VGND] = ch1_latch[`BIT_CH1_VGND_POS] | ch1_latch[`BIT_CH1_VGND_NEG]
                                      | ch2_vgnd_flag;
      mask_four_src[`BIT_HS_INSERT]   = hs_insert_flag;
      mask_four_src[`BIT_HS_REMOVE]   = hs_remove_flag;
      mask_four_src[`BIT_HS_BUTTON]   = hs_button_flag;
      mask_five_src = `RST_BYTE_ZERO;
      mask_five_src[`BIT_GPA_UPPER]   = gpa_upper_flag;
      mask_five_src[`BIT_GPA_LOWER]   = gpa_lower_flag;
      mask_five_src[`BIT_VOICE_UP]    = voice_up_flag;
      mask_five_src[`BIT_VOICE_DOWN]  = voice_down_flag;
   end

   // ==========================================
   // Register file and interrupt
   always_comb begin
      next_q        = q;
      if (clk_en) begin
         next_q.rvalid = reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_MASK_ZERO:  next_q.rdata = q.mask_zero;
               `ADDR_MASK_FOUR:  next_q.rdata = q.mask_four;
               `ADDR_MASK_FIVE:  next_q.rdata = q.mask_five;
               `ADDR_LATCH_ZERO: next_q.rdata = latch_zero;
               `ADDR_SUMMARY:    next_q.rdata = summary;
               `ADDR_CH1_LATCH:  next_q.rdata = ch1_latch;
               default:          next_q.rdata = `RST_BYTE_ZERO;
            endcase
         end
         // Reserved bits stay zero whatever is written
         if (reg_wr) begin
            case (reg_addr)
               `ADDR_MASK_ZERO: next_q.mask_zero = reg_wdata & `WMASK_MASK_ZERO;
               `ADDR_MASK_FOUR: next_q.mask_four = reg_wdata & `WMASK_MASK_FOUR;
               `ADDR_MASK_FIVE: next_q.mask_five = reg_wdata & `WMASK_MASK_FIVE;
               default: ;
            endcase
         end
         // Flags latch regardless of mask; masks only gate the output
         next_q.irq = unmasked(latch_zero, q.mask_zero)
                    | unmasked(mask_four_src, q.mask_four)
                    | unmasked(mask_five_src, q.mask_five);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q.mask_zero <= `RST_MASK_ZERO;
         q.mask_four <= `RST_MASK_FOUR;
         q.mask_five <= `RST_MASK_FIVE;
         q.rdata     <= `RST_BYTE_ZERO;
         q.rvalid    <= 1'b0;
         q.irq       <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata  = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign irq        = q.irq;

   // ==========================================
   // Checks
   a_mask_four_reset:
   assert property (@(posedge clk) rst |=> q.mask_four == 8'h00)
      else $error("mask four not 0x00 after reset");

   a_mask_five_reset:
   assert property (@(posedge clk) rst |=> q.mask_five == 8'h30)
      else $error("mask five not 0x30 after reset");

   a_mask_zero_reset:
   assert property (@(posedge clk) rst |=> q.mask_zero == 8'hC0)
      else $error("mask zero not 0xC0 after reset");

   a_mask_four_write:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_wr && reg_addr == 8'h32 |=> q.mask_four == ($past(reg_wdata) & 8'h3E))
      else $error("mask four write not stored");

   a_mask_five_write:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_wr && reg_addr == 8'h33 |=> q.mask_five == ($past(reg_wdata) & 8'hF0))
      else $error("mask five write not stored");

   a_reserved_read_zero:
   assert property (@(posedge clk) disable iff (rst)
      (q.mask_four & 8'hC1) == 8'h00 && (q.mask_five & 8'h0F) == 8'h00 && (q.mask_zero & 8'h3F) == 8'h00)
      else $error("reserved mask bit set");

   a_clock_error_set:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && clock_error_evt |=> latch_zero[7])
      else $error("clock error not latched");

   a_pll_lock_set:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && pll_lock_evt |=> latch_zero[6])
      else $error("pll lock not latched");

   a_ch1_fault_set:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && ch1_any |=> (ch1_latch & $past(ch1_set)) == $past(ch1_set))
      else $error("channel 1 fault not latched");

   a_ch1_summary_set:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && ch1_any |=> summary[5])
      else $error("channel 1 summary not set");

   a_ch2_summary_set:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && ch2_fault_evt |=> summary[4])
      else $error("channel 2 summary not set");

   a_read_clears_flags:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_rd && reg_addr == 8'h34 && !clock_error_evt && !pll_lock_evt |=> latch_zero == 8'h00)
      else $error("latched zero not cleared by read");

   a_irq_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && latch_zero[7] && !q.mask_zero[7] |=> irq)
      else $error("unmasked flag did not raise interrupt");

   a_irq_short_masked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && q.mask_four[5] && q.mask_four[4] && q.mask_four[3:1] == 3'b111 && q.mask_five[7:4] == 4'hF
      && (latch_zero & ~q.mask_zero) == 8'h00 |=> !irq)
      else $error("interrupt raised while all sources masked");

   a_read_answer:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_rd && reg_addr == 8'h35 |=> reg_rvalid && reg_rdata == $past(summary))
      else $error("summary read answer wrong");

   a_mask_zero_write:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_wr && reg_addr == 8'h2F |=> q.mask_zero == ($past(reg_wdata) & 8'hC0))
      else $error("mask zero write not stored");

   a_short_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && (ch1_latch[7] || ch1_latch[6] || ch2_short_flag) && !q.mask_four[5] |=> irq)
      else $error("unmasked short did not raise interrupt");

   a_vgnd_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && (ch1_latch[5] || ch1_latch[4] || ch2_vgnd_flag) && !q.mask_four[4] |=> irq)
      else $error("unmasked virtual ground fault did not raise interrupt");

   a_headset_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && ((hs_insert_flag && !q.mask_four[3]) || (hs_remove_flag && !q.mask_four[2])
      || (hs_button_flag && !q.mask_four[1])) |=> irq)
      else $error("unmasked headset flag did not raise interrupt");

   a_gpa_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && ((gpa_upper_flag && !q.mask_five[7]) || (gpa_lower_flag && !q.mask_five[6])) |=> irq)
      else $error("unmasked threshold flag did not raise interrupt");

   a_voice_up_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && voice_up_flag && !q.mask_five[5] |=> irq)
      else $error("unmasked voice power up did not raise interrupt");

   a_voice_down_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && voice_down_flag && !q.mask_five[4] |=> irq)
      else $error("unmasked voice power down did not raise interrupt");

   a_pll_unmasked:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && latch_zero[6] && !q.mask_zero[6] |=> irq)
      else $error("unmasked pll lock did not raise interrupt");

   a_clock_error_held:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && latch_zero[7] && !(reg_rd && reg_addr == 8'h34) |=> latch_zero[7])
      else $error("clock error flag lost without a read");

   a_ch1_read_clears:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_rd && reg_addr == 8'h38 && !ch1_any |=> ch1_latch == 8'h00)
      else $error("channel 1 latch not cleared by read");

   a_summary_clears:
   assert property (@(posedge clk) disable iff (rst)
      clk_en && reg_rd && reg_addr == 8'h35 && !ch1_any && !ch2_fault_evt |=> summary == 8'h00)
      else $error("summary not cleared by read");

   a_latch_reserved_zero:
   assert property (@(posedge clk) disable iff (rst)
      (latch_zero & 8'h3F) == 8'h00 && (summary & 8'hCF) == 8'h00 && (ch1_latch & 8'h0F) == 8'h00)
      else $error("reserved latch bit set");

endmodule // fault_interrupt_mask_latch

// File: tb/host_port_model.sv
// Host model that reads and writes the fault interrupt bank over its register port
`timescale 1ns/1ps
`include "fault_int_params.svh"

module host_port_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // ==========================================
   // Reserved bits always go out as their reset value
   function automatic logic [7:0] legal(input logic [7:0] addr, input logic [7:0] data);
      case (addr)
         `ADDR_MASK_ZERO: legal = data & `WMASK_MASK_ZERO;
         `ADDR_MASK_FOUR: legal = data & `WMASK_MASK_FOUR;
         `ADDR_MASK_FIVE: legal = data & `WMASK_MASK_FIVE;
         default:         legal = 8'h00;
      endcase
   endfunction

   // ==========================================
   // Bus cycles, entered just after a rising edge
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      reg_addr  = addr;
      reg_wdata = legal(addr, data);
      reg_wr    = 1'b1;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~addr;
      reg_wdata = ~reg_wdata;
      // Idle edge between transfers
      @(posedge clk);
      #1;
   endtask

   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      int n;
      reg_addr = addr;
      reg_rd   = 1'b1;
      @(posedge clk);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~addr;
      n        = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
      @(posedge clk);
      #1;
   endtask
endmodule // host_port_model

// File: tb/tb.sv
// Self-checking bench of the fault interrupt mask and latch bank
`timescale 1ns/1ps
`include "fault_int_params.svh"

module tb;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } row_t;

   localparam row_t ROWS [0:12] = '{
      '{`ADDR_MASK_ZERO, 1'b0, 8'h00, 8'hC0},
      '{`ADDR_MASK_FOUR, 1'b0, 8'h00, 8'h00},
      '{`ADDR_MASK_FIVE, 1'b0, 8'h00, 8'h30},
      '{`ADDR_LATCH_ZERO, 1'b0, 8'h00, 8'h00},
      '{`ADDR_SUMMARY, 1'b0, 8'h00, 8'h00},
      '{`ADDR_CH1_LATCH, 1'b0, 8'h00, 8'h00},
      '{8'h40, 1'b0, 8'h00, 8'h00},
      '{`ADDR_MASK_FOUR, 1'b1, 8'hFF, 8'h3E},
      '{`ADDR_MASK_FIVE, 1'b1, 8'hFF, 8'hF0},
      '{`ADDR_MASK_ZERO, 1'b1, 8'hFF, 8'hC0},
      '{`ADDR_MASK_FOUR, 1'b1, 8'h00, 8'h00},
      '{`ADDR_MASK_FIVE, 1'b1, 8'h00, 8'h00},
      '{`ADDR_MASK_ZERO, 1'b1, 8'h00, 8'h00}
   };
   localparam logic [7:0] EV_ADDR [0:6] = '{8'h34, 8'h34, 8'h38, 8'h38, 8'h38, 8'h38, 8'h35};
   localparam logic [7:0] EV_EXP  [0:6] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h10};
   localparam logic [7:0] LV_ADDR [0:8] = '{8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h33, 8'h33, 8'h33, 8'h33};
   localparam logic [7:0] LV_BIT  [0:8] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h80, 8'h40, 8'h20, 8'h10};

   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       clk_en = 1'b1;
   logic [6:0] evt = '0;
   logic [8:0] lvl = '0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic       reg_wr, reg_rd, reg_rvalid, irq;
   int         err_count = 0;
   int         n_checks = 0;

   always #50 clk = ~clk;

   host_port_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
                         .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

   fault_interrupt_mask_latch uut (
      .clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .clock_error_evt(evt[0]),
      .pll_lock_evt(evt[1]), .ch1_short_pos_evt(evt[2]), .ch1_short_neg_evt(evt[3]), .ch1_vgnd_pos_evt(evt[4]),
      .ch1_vgnd_neg_evt(evt[5]), .ch2_fault_evt(evt[6]), .ch2_short_flag(lvl[0]), .ch2_vgnd_flag(lvl[1]),
      .hs_insert_flag(lvl[2]), .hs_remove_flag(lvl[3]), .hs_button_flag(lvl[4]), .gpa_upper_flag(lvl[5]),
      .gpa_lower_flag(lvl[6]), .voice_up_flag(lvl[7]), .voice_down_flag(lvl[8]), .irq(irq));

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic pulse(input int i);
      evt[i] = 1'b1;
      @(posedge clk);
      #1;
      evt = '0;
      @(posedge clk);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #100_000;
      err_count++;
      finish_test;
   end

   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      foreach (ROWS[r]) begin
         if (ROWS[r].wr) begin
            host.write(ROWS[r].addr, ROWS[r].wdata);
         end
         host.read(ROWS[r].addr, d);
         chk(d, ROWS[r].exp, "register row");
      end
      $display("test register table done");
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         if (i < 6) chk({7'h00, irq}, 8'h01, "irq on event");
         host.read(EV_ADDR[i], d);
         chk(d, EV_EXP[i], "latched flag");
         if (i >= 2 && i < 6) begin
            host.read(`ADDR_SUMMARY, d);
            chk(d, 8'h20, "channel one summary");
         end
         host.read(EV_ADDR[i], d);
         chk(d, 8'h00, "flag after read");
         @(posedge clk);
         #1;
         chk({7'h00, irq}, 8'h00, "irq after clear");
      end
      $display("test latched events done");
      for (int j = 0; j < 9; j++) begin
         lvl[j] = 1'b1;
         @(posedge clk);
         #1;
         chk({7'h00, irq}, 8'h01, "irq on flag level");
         host.write(LV_ADDR[j], LV_BIT[j]);
         @(posedge clk);
         #1;
         chk({7'h00, irq}, 8'h00, "irq masked");
         lvl[j] = 1'b0;
         host.write(LV_ADDR[j], 8'h00);
      end
      $display("test mask bits done");
      host.write(`ADDR_MASK_ZERO, 8'hC0);
      pulse(0);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00, "masked clock error");
      host.read(`ADDR_LATCH_ZERO, d);
      chk(d, 8'h80, "latched while masked");
      fork
         host.read(`ADDR_LATCH_ZERO, d);
         pulse(1);
      join
      chk(d, 8'h00, "read beside event");
      host.read(`ADDR_LATCH_ZERO, d);
      chk(d, 8'h40, "set wins over clear");
      clk_en = 1'b0;
      pulse(0);
      clk_en = 1'b1;
      host.read(`ADDR_LATCH_ZERO, d);
      chk(d, 8'h00, "frozen while disabled");
      host.write(`ADDR_MASK_FOUR, 8'hFF);
      host.write(`ADDR_MASK_FIVE, 8'hFF);
      lvl = 9'h1FF;
      pulse(2);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00, "all sources masked");
      host.read(`ADDR_CH1_LATCH, d);
      chk(d, 8'h80, "latched under mask");
      lvl = '0;
      $display("test awkward cases done");
      host.write(`ADDR_MASK_FIVE, 8'h00);
      lvl = 9'h080;
      pulse(2);
      chk({7'h00, irq}, 8'h01, "irq before reset");
      rst = 1'b1;
      @(posedge clk);
      #1;
      rst = 1'b0;
      chk({6'h00, reg_rvalid, irq}, 8'h00, "outputs in reset");
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00, "voice up masked after reset");
      lvl = '0;
      host.read(`ADDR_CH1_LATCH, d);
      chk(d, 8'h00, "channel 1 latch after reset");
      host.read(`ADDR_MASK_FOUR, d);
      chk(d, 8'h00, "mask four after reset");
      host.read(`ADDR_MASK_FIVE, d);
      chk(d, 8'h30, "mask five after reset");
      host.read(`ADDR_MASK_ZERO, d);
      chk(d, 8'hC0, "mask zero after reset");
      $display("test second reset done");
      finish_test;
   end
endmodule // tb
